// ==== shared/canmb_pkg.sv ====
// Constants and carrier types for the CAN message-buffer register file
package canmb_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int             IDX_W      = 12;
   localparam logic [11:0] IDX_RX1_CR = 12'hEBD;
   localparam logic [11:0] IDX_RX0_D7 = 12'hEBE;
   localparam logic [11:0] IDX_RX0_D6 = 12'hEBF;
   localparam logic [11:0] IDX_RX0_D5 = 12'hEC0;
   localparam logic [11:0] IDX_RX0_D4 = 12'hEC1;
   localparam logic [11:0] IDX_RX0_D3 = 12'hEC2;
   localparam logic [11:0] IDX_RX0_D2 = 12'hEC3;
   localparam logic [11:0] IDX_RX0_D1 = 12'hEC4;
   localparam logic [11:0] IDX_RX0_D0 = 12'hEC5;
   localparam logic [11:0] IDX_RX0_ID3 = 12'hEC6;
   localparam logic [11:0] IDX_RX0_ID2 = 12'hEC7;
   localparam logic [11:0] IDX_RX0_ID1 = 12'hEC8;
   localparam logic [11:0] IDX_RX0_ID0 = 12'hEC9;
   localparam logic [11:0] IDX_RX0_CR = 12'hECA;
   localparam logic [11:0] IDX_TX_D7  = 12'hECB;
   localparam logic [11:0] IDX_TX_D6  = 12'hECC;
   localparam logic [11:0] IDX_TX_D5  = 12'hECD;
   localparam logic [11:0] IDX_TX_D4  = 12'hECE;
   localparam logic [11:0] IDX_TX_D3  = 12'hECF;
   localparam logic [11:0] IDX_TX_D2  = 12'hED0;
   localparam logic [11:0] IDX_TX_D1  = 12'hED1;
   localparam logic [11:0] IDX_TX_D0  = 12'hED2;
   localparam logic [11:0] IDX_TX_ID3 = 12'hED3;
   localparam logic [11:0] IDX_TX_ID2 = 12'hED4;
   localparam logic [11:0] IDX_TX_ID1 = 12'hED5;
   localparam logic [11:0] IDX_TX_ID0 = 12'hED6;
   localparam logic [11:0] IDX_TX_CR  = 12'hED7;
   localparam logic [11:0] IDX_CMD    = 12'hEE0;
   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int         CR_IDE_BIT  = 7;
   localparam int         CR_RTR_BIT  = 6;
   localparam int         ID3_EXT_LO  = 3;
   localparam int         CMD_TXREQ   = 0;
   localparam int         CMD_RXREL   = 1;
   localparam int         STAT_TXPEND = 0;
   localparam int         STAT_RXFULL = 1;
   localparam logic [3:0] DLC_MAX     = 4'h8;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [1:0] HTRANS_NSEQ = 2'h2;
   localparam logic       HRESP_OKAY  = 1'h0;
   // ----------------------------------------------------------------
   // Frame carrier between register file and protocol engine
   // ----------------------------------------------------------------
   typedef struct packed {
      logic            ide;
      logic            rtr;
      logic [3:0]      dlc;
      logic [28:0]     ident;
      logic [7:0][7:0] data;
   } canmb_frame_t;
endpackage

// ==== verilog/canmb_regs.sv ====
// CAN message-buffer register file with AHB-Lite slave and frame streams
`timescale 1ns/1ps
module canmb_regs #(
   parameter int ADDR_W = 16
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  hsel,
   input  wire logic [ADDR_W-1:0]     haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic                  rxInValid,
   output logic                       rxInReady,
   input  wire canmb_pkg::canmb_frame_t rxInFrame,
   output logic                       txOutValid,
   input  wire logic                  txOutReady,
   output canmb_pkg::canmb_frame_t    txOutFrame
);
   import canmb_pkg::*;

   // ----------------------------------------------------------------
   // AHB-Lite slave: writes take no wait, reads take one
   // ----------------------------------------------------------------
   logic [IDX_W-1:0] phIdx_r;
   logic             phWr_r;
   logic             rdWait_r;
   logic             rdShow_r;
   logic [31:0]      hrdata_r;
   logic [7:0]       rdByte;
   logic             addrOk;
   logic             wrEn;
   logic [IDX_W-1:0] addrIdx;

   assign addrIdx   = haddr[IDX_W+1:2];
   assign addrOk    = hsel && hready && (htrans == HTRANS_NSEQ);
   assign wrEn      = phWr_r && hready;
   assign hreadyout = !rdWait_r;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = hrdata_r;

   // Address phase capture; hsize is ignored as only words are used
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phIdx_r  <= '0;
         phWr_r   <= 1'b0;
         rdWait_r <= 1'b0;
      end else begin
         if (hready) begin
            phIdx_r <= addrIdx;
            phWr_r  <= addrOk && hwrite;
         end
         // The wait cycle lets a read see a write from the beat before
         rdWait_r <= addrOk && !hwrite;
      end
   end

   // Read data is latched at the end of the wait cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hrdata_r <= '0;
         rdShow_r <= 1'b0;
      end else begin
         rdShow_r <= rdWait_r;
         if (rdWait_r) begin
            hrdata_r <= {24'h000000, rdByte};
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit buffer registers
   // ----------------------------------------------------------------
   logic [7:0]      txId0_r;
   logic [7:0]      txId1_r;
   logic [7:0]      txId2_r;
   logic [4:0]      txId3_r;
   logic            txIde_r;
   logic            txRtr_r;
   logic [3:0]      txDlc_r;
   logic [7:0][7:0] txData_r;
   logic [3:0]      txIdxOff;

   assign txIdxOff = 4'(IDX_TX_D0 - phIdx_r);

   // Software writes of identifier, control and payload bytes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txId0_r  <= BYTE_RST;
         txId1_r  <= BYTE_RST;
         txId2_r  <= BYTE_RST;
         txId3_r  <= '0;
         txIde_r  <= 1'b0;
         txRtr_r  <= 1'b0;
         txDlc_r  <= '0;
         txData_r <= '0;
      end else if (wrEn) begin
         unique case (phIdx_r)
            IDX_TX_ID0: txId0_r <= hwdata[7:0];
            IDX_TX_ID1: txId1_r <= hwdata[7:0];
            IDX_TX_ID2: txId2_r <= hwdata[7:0];
            IDX_TX_ID3: txId3_r <= hwdata[7:ID3_EXT_LO];
            IDX_TX_CR: begin
               txIde_r <= hwdata[CR_IDE_BIT];
               txRtr_r <= hwdata[CR_RTR_BIT];
               txDlc_r <= hwdata[3:0];
            end
            default: begin
               if (phIdx_r >= IDX_TX_D7 && phIdx_r <= IDX_TX_D0) begin
                  txData_r[txIdxOff[2:0]] <= hwdata[7:0];
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Frame assembly for the protocol engine
   // ----------------------------------------------------------------
   canmb_frame_t    txBuild;
   logic [3:0]      txLen;
   logic [7:0][7:0] txSend;

   // A length code above eight still sends only eight bytes
   assign txLen = (txDlc_r > DLC_MAX) ? DLC_MAX : txDlc_r;

   // Standard frames drop the extended-only bytes entirely
   always_comb begin
      txBuild.ide = txIde_r;
      txBuild.rtr = txRtr_r;
      txBuild.dlc = txDlc_r;
      // Payload comes from the per-byte gates below, one driver only
      txBuild.data = txSend;
      if (txIde_r) begin
         txBuild.ident = {txId0_r, txId1_r, txId2_r, txId3_r};
      end else begin
         txBuild.ident = {18'h00000, txId0_r, txId1_r[7:5]};
      end
   end

   // Bytes past the length and all bytes of a remote frame go out zero
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gTxByte
         assign txSend[g] =
            (!txRtr_r && (4'(g) < txLen)) ? txData_r[g] : BYTE_RST;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Command register: transmit request and receive release
   // ----------------------------------------------------------------
   logic txPend_r;
   logic txReq;
   logic txLoad;

   assign txReq      = wrEn && (phIdx_r == IDX_CMD) && hwdata[CMD_TXREQ];
   assign txLoad     = txReq && (!txPend_r || txOutReady);
   assign txOutValid = txPend_r;

   // A request while the previous frame is still offered and txOutReady is low is dropped
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txPend_r   <= 1'b0;
         txOutFrame <= '0;
      end else if (txLoad) begin
         txPend_r   <= 1'b1;
         txOutFrame <= txBuild;
      end else if (txOutReady) begin
         txPend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receive path: two-entry buffer ahead of receive buffer 0
   // ----------------------------------------------------------------
   canmb_frame_t fifoMem [2];
   logic         fifoWp_r;
   logic         fifoRp_r;
   logic [1:0]   fifoCnt_r;
   logic         push;
   logic         pop;
   logic         rx0Full_r;
   logic         rxRel;
   canmb_frame_t rx0Frame_r;
   logic [7:0]   rx0Ctrl;
   logic [7:0]   rx1Ctrl_r;

   assign rxInReady = (fifoCnt_r != 2'h2);
   assign push      = rxInValid && rxInReady;
   // Buffer 0 is held until software releases it, so the buffer fills
   assign pop       = (fifoCnt_r != 2'h0) && !rx0Full_r;
   assign rxRel     = wrEn && (phIdx_r == IDX_CMD) && hwdata[CMD_RXREL];
   assign rx0Ctrl   = {rx0Frame_r.ide, rx0Frame_r.rtr, 2'h0, rx0Frame_r.dlc};

   // Buffer storage and pointers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fifoWp_r  <= 1'b0;
         fifoRp_r  <= 1'b0;
         fifoCnt_r <= '0;
         fifoMem   <= '{default: '0};
      end else begin
         if (push) begin
            fifoMem[fifoWp_r] <= rxInFrame;
            fifoWp_r          <= !fifoWp_r;
         end
         if (pop) begin
            fifoRp_r <= !fifoRp_r;
         end
         fifoCnt_r <= 2'(fifoCnt_r + {1'b0, push} - {1'b0, pop});
      end
   end

   // Older frame's control byte moves on to receive buffer 1
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx0Frame_r <= '0;
         rx1Ctrl_r  <= BYTE_RST;
      end else if (pop) begin
         rx0Frame_r <= fifoMem[fifoRp_r];
         rx1Ctrl_r  <= rx0Ctrl;
      end
   end

   // Full flag: a load in the release cycle keeps it set
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx0Full_r <= 1'b0;
      end else if (pop) begin
         rx0Full_r <= 1'b1;
      end else if (rxRel) begin
         rx0Full_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read multiplexer; receive bytes are views of the stored frame
   // ----------------------------------------------------------------
   logic [3:0] rxIdxOff;

   assign rxIdxOff = 4'(IDX_RX0_D0 - phIdx_r);

   // Unmapped indices and reserved bits read as zero
   always_comb begin
      rdByte = BYTE_RST;
      unique case (phIdx_r)
         IDX_RX1_CR:  rdByte = rx1Ctrl_r;
         IDX_RX0_CR:  rdByte = rx0Ctrl;
         IDX_RX0_ID0: rdByte = rx0Frame_r.ide ? rx0Frame_r.ident[28:21]
                                              : rx0Frame_r.ident[10:3];
         IDX_RX0_ID1: rdByte = rx0Frame_r.ide ? rx0Frame_r.ident[20:13]
                                              : {rx0Frame_r.ident[2:0], 5'h00};
         IDX_RX0_ID2: rdByte = rx0Frame_r.ide ? rx0Frame_r.ident[12:5] : BYTE_RST;
         IDX_RX0_ID3: rdByte = rx0Frame_r.ide ? {rx0Frame_r.ident[4:0], 3'h0}
                                              : BYTE_RST;
         IDX_TX_ID0:  rdByte = txId0_r;
         IDX_TX_ID1:  rdByte = txId1_r;
         IDX_TX_ID2:  rdByte = txId2_r;
         IDX_TX_ID3:  rdByte = {txId3_r, 3'h0};
         IDX_TX_CR:   rdByte = {txIde_r, txRtr_r, 2'h0, txDlc_r};
         IDX_CMD:     rdByte = {4'h0, fifoCnt_r, rx0Full_r, txPend_r};
         default: begin
            if (phIdx_r >= IDX_RX0_D7 && phIdx_r <= IDX_RX0_D0) begin
               rdByte = rx0Frame_r.data[rxIdxOff[2:0]];
            end else if (phIdx_r >= IDX_TX_D7 && phIdx_r <= IDX_TX_D0) begin
               rdByte = txData_r[txIdxOff[2:0]];
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Checks on the design's own behaviour
   // ----------------------------------------------------------------
   default clocking cbDef @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_TXID2_RW: assert property (
      wrEn && phIdx_r == IDX_TX_ID2 ##1 addrOk && !hwrite && addrIdx == IDX_TX_ID2
      |-> ##2 hrdata[7:0] == $past(txId2_r, 2))
      else $error("tx ident byte 2 readback wrong");
   AST_ID3_RSV: assert property (
      rdShow_r && (phIdx_r == IDX_RX0_ID3 || phIdx_r == IDX_TX_ID3)
      |-> hrdata[2:0] == 3'h0)
      else $error("ident byte 3 reserved bits not zero");
   AST_TXD0_WR: assert property (
      wrEn && phIdx_r == IDX_TX_D0 |=> txData_r[0] == $past(hwdata[7:0]))
      else $error("tx payload byte 0 not written");
   AST_RXCR_FLAGS: assert property (
      rdShow_r && phIdx_r == IDX_RX0_CR
      |-> hrdata[7:6] == {rx0Frame_r.ide, rx0Frame_r.rtr})
      else $error("rx control flags wrong");
   AST_RXCR_RO: assert property (
      wrEn && phIdx_r == IDX_RX0_CR && !pop |=> $stable(rx0Frame_r))
      else $error("rx control changed by write");
   AST_RXID0: assert property (
      rdShow_r && phIdx_r == IDX_RX0_ID0 && !$past(pop)
      |-> hrdata[7:0] == (rx0Frame_r.ide ? rx0Frame_r.ident[28:21]
                                         : rx0Frame_r.ident[10:3]))
      else $error("rx ident byte 0 wrong");
   AST_RXID1: assert property (
      rdShow_r && phIdx_r == IDX_RX0_ID1 && !rx0Frame_r.ide && !$past(pop)
      |-> hrdata[7:0] == {rx0Frame_r.ident[2:0], 5'h00})
      else $error("rx ident byte 1 wrong");
   AST_TXEXT: assert property (
      txLoad && txIde_r |=> txOutFrame.ident[17:13] == $past(txId1_r[4:0])
                            && txOutFrame.ide)
      else $error("extended ident bits misplaced");
   AST_TXSTD: assert property (
      txLoad && !txIde_r |=> txOutFrame.ident[28:11] == 18'h00000)
      else $error("standard frame carries extended bits");
   AST_RXLOAD: assert property (
      pop |=> rx0Full_r && rx0Frame_r == $past(fifoMem[fifoRp_r]))
      else $error("rx buffer 0 load wrong");
   AST_REMOTE: assert property (
      txOutValid && txOutFrame.rtr |-> txOutFrame.data == '0)
      else $error("remote frame has payload");
   // A full buffer must refuse, so no stored frame may be overwritten
   AST_FULLSTALL: assert property (
      fifoCnt_r == 2'h2 |=> $stable(fifoMem[0]) && $stable(fifoMem[1]))
      else $error("buffer overrun");

   COV_TX: cover property (txOutValid && txOutReady);
   COV_FIFOFULL: cover property (fifoCnt_r == 2'h2 && rxInValid);
   COV_RDCR: cover property (rdShow_r && phIdx_r == IDX_RX0_CR);
   COV_TXEXT: cover property (txLoad && txIde_r);
endmodule

// ==== bench/canmb_engine_model.sv ====
// Behavioural protocol engine facing the frame streams of the register file
`timescale 1ns/1ps
module canmb_engine_model (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire logic                    txStall,
   output logic                         rxInValid,
   input  wire logic                    rxInReady,
   output canmb_pkg::canmb_frame_t      rxInFrame,
   input  wire logic                    txOutValid,
   output logic                         txOutReady,
   input  wire canmb_pkg::canmb_frame_t txOutFrame
);
   import canmb_pkg::*;

   canmb_frame_t txSeen = '0;
   int           txCount = 0;

   // ----------------------------------------------------------------
   // Idle stream state
   // ----------------------------------------------------------------
   initial begin
      rxInValid = 1'b0;
      rxInFrame = '1;
   end

   // A stalled engine refuses frames until the bench lets go
   assign txOutReady = !txStall;

   // Capture each frame handed over, so the bench can count drops
   always @(posedge clk_sys) begin
      if (rst) begin
         txCount <= 0;
      end else if (txOutValid && txOutReady) begin
         txSeen  <= txOutFrame;
         txCount <= txCount + 1;
      end
   end

   // Offer one frame, hold it until taken; released data is inverted
   // No limit of its own: a hang is ended by the bench watchdog
   task automatic pushFrame(input canmb_frame_t f);
      @(posedge clk_sys);
      rxInValid <= 1'b1;
      rxInFrame <= f;
      @(negedge clk_sys);
      while (rxInReady !== 1'b1) begin
         @(negedge clk_sys);
      end
      @(posedge clk_sys);
      rxInValid <= 1'b0;
      rxInFrame <= ~f;
   endtask
endmodule

// ==== bench/canmb_tb.sv ====
// Self-checking testbench for the CAN message-buffer register file
`timescale 1ns/1ps
module tb;
   import canmb_pkg::*;

   logic         clk_sys;
   logic         rst;
   logic         hsel;
   logic [15:0]  haddr;
   logic [1:0]   htrans;
   logic         hwrite;
   logic [2:0]   hsize;
   logic [31:0]  hwdata;
   logic         hreadyout;
   logic         hresp;
   logic [31:0]  hrdata;
   logic         rxInValid;
   logic         rxInReady;
   logic         txOutValid;
   logic         txOutReady;
   logic         txStall;
   canmb_frame_t rxInFrame;
   canmb_frame_t txOutFrame;
   int           err_count;
   int           samples_checked;
   logic [7:0]   txPay [8];
   logic [7:0]   txId [4];
   canmb_frame_t fr [4];

   canmb_regs #(.ADDR_W(16)) dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxInValid(rxInValid),
      .rxInReady(rxInReady), .rxInFrame(rxInFrame), .txOutValid(txOutValid),
      .txOutReady(txOutReady), .txOutFrame(txOutFrame));

   canmb_engine_model eng_u (.clk_sys(clk_sys), .rst(rst), .txStall(txStall),
      .rxInValid(rxInValid), .rxInReady(rxInReady), .rxInFrame(rxInFrame),
      .txOutValid(txOutValid), .txOutReady(txOutReady), .txOutFrame(txOutFrame));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Compare, bus and expectation helpers
   // ----------------------------------------------------------------
   task automatic checkVal(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic checkFrame(input canmb_frame_t exp, input canmb_frame_t got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED tx frame expected %h seen %h", exp, got);
      end
   endtask

   // Hready is looked at on the falling edge: it is settled there until the next rise
   task automatic waitReady(output logic [31:0] rd);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (hreadyout !== 1'b1 && n < 20) begin
         n++;
         @(negedge clk_sys);
      end
      if (n == 20) err_count++;
      rd = hrdata;
      checkVal("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
      @(posedge clk_sys);
   endtask

   task automatic busXfer(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                          output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {2'h0, idx, 2'h0};
      htrans <= HTRANS_NSEQ;
      hwrite <= wr;
      waitReady(rd);
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      waitReady(rd);
   endtask

   task automatic regWr(input logic [11:0] idx, input logic [7:0] wd);
      logic [31:0] rd;
      busXfer(1'b1, idx, wd, rd);
   endtask

   // Reserved bits are masked out; the upper 24 bits must read zero
   task automatic regChk(input logic [11:0] idx, input logic [7:0] exp, input logic [7:0] mask);
      logic [31:0] rd;
      busXfer(1'b0, idx, 8'h00, rd);
      checkVal($sformatf("reg %h", idx), {24'h000000, exp & mask}, rd & {24'hFFFFFF, mask});
   endtask

   function automatic logic [7:0] maskOf(input logic [11:0] i);
      if (i == IDX_RX0_ID3 || i == IDX_TX_ID3) return 8'hF8;
      if (i == IDX_RX0_CR || i == IDX_RX1_CR) return 8'hCF;
      return 8'hFF;
   endfunction

   function automatic logic [7:0] expRx(input canmb_frame_t f, input logic [11:0] i);
      case (i)
         IDX_RX0_CR:  return {f.ide, f.rtr, 2'h0, f.dlc};
         IDX_RX0_ID0: return f.ide ? f.ident[28:21] : f.ident[10:3];
         IDX_RX0_ID1: return f.ide ? f.ident[20:13] : {f.ident[2:0], 5'h00};
         IDX_RX0_ID2: return f.ide ? f.ident[12:5] : 8'h00;
         IDX_RX0_ID3: return f.ide ? {f.ident[4:0], 3'h0} : 8'h00;
         default:     return f.data[3'(IDX_RX0_D0 - i)];
      endcase
   endfunction

   function automatic canmb_frame_t expTx(input logic [7:0] c);
      canmb_frame_t f;
      f = '0;
      f.ide = c[7];
      f.rtr = c[6];
      f.dlc = c[3:0];
      f.ident = c[7] ? {txId[0], txId[1], txId[2], txId[3][7:3]} : {18'h0, txId[0], txId[1][7:5]};
      for (int g = 0; g < 8; g++) begin
         if (!c[6] && g < c[3:0]) f.data[g] = txPay[g];
      end
      return f;
   endfunction

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      int         n;
      logic [7:0] prev;
      logic [7:0] tc [4];
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 16'h0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      txStall = 1'b0;
      err_count = 0;
      samples_checked = 0;
      fr[0] = {1'h1, 1'h0, 4'h8, 29'h1ABCDEF3, 64'h8877665544332211};
      fr[1] = {1'h0, 1'h1, 4'h0, 29'h000005A5, 64'h0000000000000000};
      fr[2] = {1'h0, 1'h0, 4'h3, 29'h000007FF, 64'h0000000000CCBBAA};
      fr[3] = {1'h1, 1'h1, 4'h4, 29'h00000001, 64'hFEDCBA9876543210};
      tc = '{8'h85, 8'h48, 8'h08, 8'h80};
      txId = '{8'hB6, 8'h3D, 8'hC3, 8'hAF};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 12'hEBD; i <= 12'hED4; i++) begin
         regChk(12'(i), 8'h00, maskOf(12'(i)));
      end
      // Unmapped place and read-only places ignore writes
      regWr(12'h001, 8'hFF);
      regChk(12'h001, 8'h00, 8'hFF);
      regWr(IDX_RX0_D0, 8'hFF);
      regChk(IDX_RX0_D0, 8'h00, 8'hFF);
      regWr(IDX_RX0_CR, 8'hFF);
      regChk(IDX_RX0_CR, 8'h00, 8'hCF);
      for (int g = 0; g < 8; g++) begin
         txPay[g] = 8'(8'h1D * (g + 1));
         regWr(12'(IDX_TX_D0 - g), txPay[g]);
      end
      for (int k = 0; k < 4; k++) regWr(12'(IDX_TX_ID0 - k), txId[k]);
      for (int g = 0; g < 8; g++) begin
         regChk(12'(IDX_TX_D0 - g), txPay[g], 8'hFF);
      end
      regWr(IDX_TX_ID2, txId[2]);
      regChk(IDX_TX_ID2, txId[2], 8'hFF);
      regChk(IDX_TX_ID3, txId[3], 8'hF8);
      // Extended, standard remote, standard data and empty frames, each requested twice while stalled
      for (int k = 0; k < 4; k++) begin
         regWr(IDX_TX_CR, tc[k]);
         txStall <= 1'b1;
         regWr(IDX_CMD, 8'h01);
         regWr(IDX_CMD, 8'h01);
         regChk(IDX_CMD, 8'h01, 8'h01);
         txStall <= 1'b0;
         n = 0;
         while (eng_u.txCount != k + 1 && n < 50) begin
            n++;
            @(negedge clk_sys);
         end
         repeat (8) @(posedge clk_sys);
         checkVal("tx count", 32'(k + 1), 32'(eng_u.txCount));
         checkFrame(expTx(tc[k]), eng_u.txSeen);
      end
      // Fill rx0 and both buffer entries, then a fourth frame must wait
      for (int k = 0; k < 3; k++) eng_u.pushFrame(fr[k]);
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      checkVal("rx ready", 32'h00000000, {31'h0, rxInReady});
      @(posedge clk_sys);
      regChk(IDX_CMD, 8'h0A, 8'h0E);
      fork
         eng_u.pushFrame(fr[3]);
      join_none
      prev = 8'h00;
      for (int k = 0; k < 4; k++) begin
         regChk(IDX_RX1_CR, prev, 8'hCF);
         for (int i = IDX_RX0_D7; i <= IDX_RX0_CR; i++) begin
            regChk(12'(i), expRx(fr[k], 12'(i)), maskOf(12'(i)));
         end
         prev = expRx(fr[k], IDX_RX0_CR);
         regWr(IDX_CMD, 8'h02);
         repeat (3) @(posedge clk_sys);
      end
      regChk(IDX_CMD, 8'h00, 8'h0E);
      end_of_test();
   end
endmodule
